/* File: core/cad_decoder.sv */
/*
 * Decoder for multiplier, shifter and integer ALU instruction words.
 * Assumes one word offered per cycle with a valid strobe and a separate
 * flag telling whether the same line holds an immediate extension for
 * the same integer unit. Outputs are registered, one cycle of latency.
 */
`timescale 1ns/100ps
`default_nettype none
module cad_decoder #(
    parameter int WORD_W = 32
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire logic [WORD_W-1:0] INSTR_WORD,
    input wire logic IS_MULT,
    input wire logic IS_SHIFT,
    input wire logic IMM_EXT_VALID,
    input wire logic [cad_pkg::IMM_EXT_W-1:0] IMM_EXT_VALUE,
    output logic DEC_VALID,
    output logic ILLEGAL,
    output logic LINE_END,
    output logic COND_EXEC,
    output logic INT_OP,
    output logic INT_REGULAR,
    output logic INT_UNIT_SEL,
    output logic [4:0] INT_OPCODE,
    output logic [4:0] INT_RESULT_REG,
    output logic [4:0] INT_SRC1_REG,
    output logic [4:0] INT_SRC2_REG,
    output logic INT_SRC2_IMM,
    output logic [31:0] INT_IMM,
    output logic [1:0] MOVE_SIZE,
    output logic [1:0] MUL_SIGN,
    output logic MUL_INTEGER,
    output logic MUL_UNSIGNED,
    output logic MUL_SATURATE,
    output logic MUL_TRUNCATE,
    output logic MUL_ACC_CLEAR,
    output logic MUL_ACC_ROUND_SET,
    output logic [1:0] MUL_ACC_SEL,
    output logic [4:0] MUL_SUBOP,
    output logic MUL_SUBOP_ACC,
    output logic MUL_SUBOP_READ,
    output logic MUL_FLOAT,
    output logic MUL_OVF_QUAD,
    output logic [3:0] SHF_MAG_BITS,
    output logic [6:0] SHF_IMM,
    output logic SHF_LONG,
    output logic SHF_SHORT,
    output logic SHF_SIGN_EXT,
    output logic SHF_ZERO_FILL,
    output logic SHF_BIT_DUAL,
    output logic SHF_BIT_IMM,
    output logic [1:0] SHF_BIT_OP
);
    // ****************************************************************
    // Field slicing
    // ****************************************************************
    logic [3:0] typ;
    logic [4:0] opt;
    logic [4:0] dst;
    logic [4:0] src1;
    logic [4:0] src2;
    assign typ = INSTR_WORD[cad_pkg::TYPE_HI:cad_pkg::TYPE_LO];
    assign opt = INSTR_WORD[cad_pkg::OPT_HI:cad_pkg::OPT_LO];
    assign dst = INSTR_WORD[cad_pkg::DST_HI:cad_pkg::DST_LO];
    assign src1 = INSTR_WORD[cad_pkg::SRC1_HI:cad_pkg::SRC1_LO];
    assign src2 = INSTR_WORD[cad_pkg::SRC2_HI:cad_pkg::SRC2_LO];

    logic is_int_d;
    logic [1:0] kind;
    assign is_int_d = !INSTR_WORD[cad_pkg::CLASS_BIT];
    assign kind = INSTR_WORD[cad_pkg::KIND_HI:cad_pkg::KIND_LO];

    // ****************************************************************
    // Multiplier decode
    // ****************************************************************
    logic [1:0] sign_d;
    logic sign_y;
    // Second operand sign bit moves per form; U-only forms never set it
    assign sign_y = (typ == 4'h0) ? opt[2] : ((typ == 4'h1) ? opt[0] : 1'b0);
    logic [1:0] acc_d;
    logic mul_bad_d;
    logic opt_trunc;
    logic opt_integer;
    always_comb begin
        sign_d = cad_pkg::CAD_SGN_SS;
        unique case ({opt[4], sign_y})
            2'h0: sign_d = cad_pkg::CAD_SGN_SS;
            2'h2: sign_d = cad_pkg::CAD_SGN_UU;
            2'h1: sign_d = cad_pkg::CAD_SGN_SU;
            default: sign_d = cad_pkg::CAD_SGN_BAD;
        endcase
        acc_d = cad_pkg::CAD_ACC_ALL;
        unique case (opt[1:0])
            2'h0: acc_d = cad_pkg::CAD_ACC_ALL;
            2'h1: acc_d = cad_pkg::CAD_ACC_UPPER;
            2'h2: acc_d = cad_pkg::CAD_ACC_LOWER;
            default: acc_d = cad_pkg::CAD_ACC_BAD;
        endcase
        // Types 0110 and 0111 have no multiplier form
        mul_bad_d = (typ == 4'h6) || (typ == 4'h7);
        if (sign_d == cad_pkg::CAD_SGN_BAD) begin
            mul_bad_d = 1'b1;
        end
        if (typ == cad_pkg::MT_QUAD_XFER && acc_d == cad_pkg::CAD_ACC_BAD) begin
            mul_bad_d = 1'b1;
        end
        if (typ == cad_pkg::MT_ACC_ONLY && (dst > cad_pkg::ACC_SUB_MAX
                || (dst >= cad_pkg::ACC_SUB_GAP_LO && dst <= cad_pkg::ACC_SUB_GAP_HI))) begin
            mul_bad_d = 1'b1;
        end
        if (typ == cad_pkg::MT_READOUT && src1 > cad_pkg::READOUT_MAX) begin
            mul_bad_d = 1'b1;
        end
    end
    assign opt_integer = opt[3];
    // Truncation is meaningless for integer results, so it is masked here
    assign opt_trunc = opt[1] && !opt_integer;

    // ****************************************************************
    // Shifter decode
    // ****************************************************************
    logic shf_long_d;
    logic shf_short_d;
    logic shf_bad_d;
    logic [3:0] mag_d;
    logic [6:0] imm_d;
    always_comb begin
        shf_long_d = 1'b0;
        shf_short_d = 1'b0;
        if (typ >= cad_pkg::ST_DUAL_LO && typ <= cad_pkg::ST_DUAL_HI) begin
            shf_long_d = INSTR_WORD[0];
        end
        if (typ >= cad_pkg::ST_SB_LO && typ <= cad_pkg::ST_SB_HI) begin
            shf_short_d = INSTR_WORD[0];
        end
        // Magnitude width follows element size
        if (typ >= cad_pkg::ST_SB_LO && typ <= cad_pkg::ST_SB_HI) begin
            mag_d = shf_short_d ? 4'(cad_pkg::MAG_SHORT_W) : 4'(cad_pkg::MAG_BYTE_W);
        end else if (shf_long_d) begin
            mag_d = 4'(cad_pkg::MAG_LONG_W);
        end else begin
            mag_d = 4'(cad_pkg::MAG_WORD_W);
        end
        imm_d = {2'h0, src2};
        if (typ < cad_pkg::ST_DUAL_LO || typ == cad_pkg::ST_BITOP) begin
            imm_d = {1'b0, opt[0], src2};
        end else if (typ <= cad_pkg::ST_DUAL_HI) begin
            imm_d = {opt[1:0], src2};
        end
        shf_bad_d = (typ == 4'h3) || (typ == 4'h7) || (typ > cad_pkg::ST_MISC);
    end

    // ****************************************************************
    // Integer ALU decode
    // ****************************************************************
    logic [31:0] int_imm_d;
    logic [1:0] move_size_d;
    always_comb begin
        if (IMM_EXT_VALID) begin
            int_imm_d = {IMM_EXT_VALUE, INSTR_WORD[7:0]};
        end else begin
            int_imm_d = {{24{INSTR_WORD[7]}}, INSTR_WORD[7:0]};
        end
        if (!INSTR_WORD[cad_pkg::LQ_BIT]) begin
            move_size_d = cad_pkg::CAD_SZ_WORD;
        end else if (INSTR_WORD[0]) begin
            move_size_d = cad_pkg::CAD_SZ_QUAD;
        end else begin
            move_size_d = cad_pkg::CAD_SZ_LONG;
        end
    end

    // ****************************************************************
    // Registered outputs: common
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DEC_VALID <= 1'b0;
            ILLEGAL <= 1'b0;
            LINE_END <= 1'b0;
            COND_EXEC <= 1'b0;
        end else begin
            DEC_VALID <= INSTR_VALID;
            LINE_END <= INSTR_VALID && INSTR_WORD[cad_pkg::LINE_END_BIT];
            COND_EXEC <= INSTR_VALID && INSTR_WORD[cad_pkg::COND_EXEC_BIT];
            ILLEGAL <= INSTR_VALID && !is_int_d
                && ((IS_MULT && mul_bad_d) || (IS_SHIFT && shf_bad_d));
        end
    end

    // ****************************************************************
    // Registered outputs: integer unit
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            INT_OP <= 1'b0;
            INT_REGULAR <= 1'b0;
            INT_UNIT_SEL <= 1'b0;
            INT_OPCODE <= 5'h0;
            INT_RESULT_REG <= 5'h0;
            INT_SRC1_REG <= 5'h0;
            INT_SRC2_REG <= 5'h0;
            INT_SRC2_IMM <= 1'b0;
            INT_IMM <= 32'h0000_0000;
            MOVE_SIZE <= 2'h0;
        end else begin
            INT_OP <= INSTR_VALID && is_int_d;
            INT_REGULAR <= INSTR_VALID && is_int_d && kind == cad_pkg::KIND_REGULAR;
            INT_UNIT_SEL <= INSTR_WORD[cad_pkg::UNIT_SEL_BIT];
            INT_OPCODE <= INSTR_WORD[cad_pkg::IOP_HI:cad_pkg::IOP_LO];
            INT_RESULT_REG <= dst;
            INT_SRC1_REG <= src1;
            INT_SRC2_IMM <= INSTR_WORD[cad_pkg::IMM_SEL_BIT];
            INT_SRC2_REG <= INSTR_WORD[cad_pkg::IMM_SEL_BIT] ? 5'h0 : src2;
            INT_IMM <= INSTR_WORD[cad_pkg::IMM_SEL_BIT] ? int_imm_d : 32'h0000_0000;
            MOVE_SIZE <= (kind == cad_pkg::KIND_MOVE) ? move_size_d : 2'h0;
        end
    end

    // ****************************************************************
    // Registered outputs: multiplier
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MUL_SIGN <= 2'h0;
            MUL_INTEGER <= 1'b0;
            MUL_UNSIGNED <= 1'b0;
            MUL_SATURATE <= 1'b0;
            MUL_TRUNCATE <= 1'b0;
            MUL_ACC_CLEAR <= 1'b0;
            MUL_ACC_ROUND_SET <= 1'b0;
            MUL_ACC_SEL <= 2'h0;
            MUL_SUBOP <= 5'h0;
            MUL_SUBOP_ACC <= 1'b0;
            MUL_SUBOP_READ <= 1'b0;
            MUL_FLOAT <= 1'b0;
            MUL_OVF_QUAD <= 1'b0;
        end else begin
            MUL_SIGN <= sign_d;
            MUL_INTEGER <= opt_integer;
            MUL_UNSIGNED <= opt[4];
            MUL_SATURATE <= opt[0];
            MUL_TRUNCATE <= opt_trunc;
            MUL_ACC_CLEAR <= opt[2];
            // Round preset only with clear; R alone is not a listed combination
            MUL_ACC_ROUND_SET <= opt[2] && opt[1];
            MUL_ACC_SEL <= acc_d;
            MUL_SUBOP <= (typ == cad_pkg::MT_READOUT) ? src1 : dst;
            MUL_SUBOP_ACC <= typ == cad_pkg::MT_ACC_ONLY;
            MUL_SUBOP_READ <= typ == cad_pkg::MT_READOUT;
            MUL_FLOAT <= typ == cad_pkg::MT_FLOAT;
            // Quad 16-bit forms split the overflow register into four 8-bit fields
            MUL_OVF_QUAD <= typ == 4'h3 || typ[3:1] == 3'h4 || typ == 4'hA || typ == 4'hB;
        end
    end

    // ****************************************************************
    // Registered outputs: shifter
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            SHF_MAG_BITS <= 4'h0;
            SHF_IMM <= 7'h00;
            SHF_LONG <= 1'b0;
            SHF_SHORT <= 1'b0;
            SHF_SIGN_EXT <= 1'b0;
            SHF_ZERO_FILL <= 1'b0;
            SHF_BIT_DUAL <= 1'b0;
            SHF_BIT_IMM <= 1'b0;
            SHF_BIT_OP <= 2'h0;
        end else begin
            SHF_MAG_BITS <= mag_d;
            SHF_IMM <= imm_d;
            SHF_LONG <= shf_long_d;
            SHF_SHORT <= shf_short_d;
            SHF_SIGN_EXT <= opt[0];
            SHF_ZERO_FILL <= opt[1];
            SHF_BIT_DUAL <= typ == cad_pkg::ST_BITOP && opt[1];
            SHF_BIT_IMM <= typ == cad_pkg::ST_BITOP && opt[2];
            SHF_BIT_OP <= opt[4:3];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_sign;
        @(posedge CLOCK) disable iff (RST)
        (typ == 4'h0 && opt[4] && !opt[2]) |=> (MUL_SIGN == cad_pkg::CAD_SGN_UU);
    endproperty
    a_sign: assert property (p_sign) else $error("sign decode wrong");
    property p_trunc;
        @(posedge CLOCK) disable iff (RST)
        MUL_TRUNCATE |-> MUL_INTEGER == 1'b0;
    endproperty
    a_trunc: assert property (p_trunc) else $error("truncate with integer");
    property p_round;
        @(posedge CLOCK) disable iff (RST)
        MUL_ACC_ROUND_SET |-> MUL_ACC_CLEAR;
    endproperty
    a_round: assert property (p_round) else $error("round preset without clear");
    property p_mag;
        @(posedge CLOCK) disable iff (RST)
        SHF_LONG |-> SHF_MAG_BITS == 4'h8;
    endproperty
    a_mag: assert property (p_mag) else $error("long magnitude width");
    property p_int;
        @(posedge CLOCK) disable iff (RST)
        (INSTR_VALID && INSTR_WORD[29]) |=> !INT_OP;
    endproperty
    a_int: assert property (p_int) else $error("bit 29 set yet integer");
    property p_unit;
        @(posedge CLOCK) disable iff (RST)
        INSTR_VALID |=> INT_UNIT_SEL == $past(INSTR_WORD[28]);
    endproperty
    a_unit: assert property (p_unit) else $error("unit select");
    property p_imm;
        @(posedge CLOCK) disable iff (RST)
        (INSTR_WORD[13] && !IMM_EXT_VALID) |=> INT_IMM[31:8] == {24{INT_IMM[7]}};
    endproperty
    a_imm: assert property (p_imm) else $error("immediate extension");
    property p_end;
        @(posedge CLOCK) disable iff (RST)
        (INSTR_VALID && INSTR_WORD[31]) |=> LINE_END && DEC_VALID;
    endproperty
    a_end: assert property (p_end) else $error("line end lost");
    property p_cond;
        @(posedge CLOCK) disable iff (RST)
        COND_EXEC |-> DEC_VALID;
    endproperty
    a_cond: assert property (p_cond) else $error("cond without valid");
    c_float: cover property (@(posedge CLOCK) MUL_FLOAT && DEC_VALID);
    c_illegal: cover property (@(posedge CLOCK) ILLEGAL);
    c_quad: cover property (@(posedge CLOCK) MOVE_SIZE == cad_pkg::CAD_SZ_QUAD);
endmodule
`default_nettype wire

/* File: core/cad_pkg.sv */
/*
 * Constants shared by the compute and integer ALU instruction decoder.
 * Assumes 32-bit instruction words, bit 0 the least significant.
 */
package cad_pkg;
    // ****************************************************************
    // Common word fields
    // ****************************************************************
    localparam int LINE_END_BIT = 31;
    localparam int COND_EXEC_BIT = 30;
    localparam int CLASS_BIT = 29;
    localparam int UNIT_SEL_BIT = 28;
    localparam int KIND_HI = 27;
    localparam int KIND_LO = 26;
    localparam int TYPE_HI = 24;
    localparam int TYPE_LO = 21;
    localparam int DST_HI = 20;
    localparam int DST_LO = 16;
    localparam int SRC1_HI = 12;
    localparam int SRC1_LO = 8;
    localparam int OPC_HI = 7;
    localparam int OPC_LO = 3;
    localparam int OPT_HI = 4;
    localparam int OPT_LO = 0;
    // ****************************************************************
    // Integer unit fields
    // ****************************************************************
    localparam logic [1:0] KIND_REGULAR = 2'h3;
    localparam logic [1:0] KIND_MOVE = 2'h2;
    localparam int IOP_HI = 25;
    localparam int IOP_LO = 21;
    localparam int IMM_SEL_BIT = 13;
    localparam int SRC2_HI = 5;
    localparam int SRC2_LO = 1;
    localparam int LQ_BIT = 14;
    localparam int IMM_EXT_W = 24;
    // ****************************************************************
    // Multiplier type codes
    // ****************************************************************
    localparam logic [3:0] MT_ACC_ONLY = 4'h D;
    localparam logic [3:0] MT_READOUT = 4'h E;
    localparam logic [3:0] MT_FLOAT = 4'h F;
    localparam logic [3:0] MT_QUAD_XFER = 4'h C;
    localparam logic [4:0] ACC_SUB_MAX = 5'h10;
    localparam logic [4:0] ACC_SUB_GAP_LO = 5'h0B;
    localparam logic [4:0] ACC_SUB_GAP_HI = 5'h0D;
    localparam logic [4:0] READOUT_MAX = 5'h08;
    // ****************************************************************
    // Shifter type codes and magnitude widths
    // ****************************************************************
    localparam logic [3:0] ST_BITOP = 4'hB;
    localparam logic [3:0] ST_DUAL_LO = 4'h4;
    localparam logic [3:0] ST_DUAL_HI = 4'h6;
    localparam logic [3:0] ST_SB_LO = 4'h8;
    localparam logic [3:0] ST_SB_HI = 4'hA;
    localparam logic [3:0] ST_MISC = 4'hC;
    localparam int MAG_BYTE_W = 5;
    localparam int MAG_SHORT_W = 6;
    localparam int MAG_WORD_W = 7;
    localparam int MAG_LONG_W = 8;

    typedef enum logic [1:0] {CAD_SGN_SS, CAD_SGN_SU, CAD_SGN_UU, CAD_SGN_BAD} cad_sign_e;
    typedef enum logic [1:0] {CAD_ACC_ALL, CAD_ACC_UPPER, CAD_ACC_LOWER, CAD_ACC_BAD} cad_acc_e;
    typedef enum logic [1:0] {CAD_BIT_CLR, CAD_BIT_SET, CAD_BIT_TGL, CAD_BIT_TST} cad_bitop_e;
    typedef enum logic [1:0] {CAD_SZ_WORD, CAD_SZ_LONG, CAD_SZ_QUAD} cad_size_e;
endpackage

/* File: dv/cad_seq_model.sv */
/*
 * Fetch and sequencer stand-in that offers one word per call to the decoder.
 * Assumes a single clock; words change 1 ns after the rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module cad_seq_model (
    input wire logic clock,
    output var logic instr_valid,
    output var logic [31:0] instr_word,
    output var logic is_mult,
    output var logic is_shift,
    output var logic imm_ext_valid,
    output var logic [23:0] imm_ext_value
);
    // ****************************************************************
    // Word issue
    // ****************************************************************
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0000_0000;
        is_mult = 1'b0;
        is_shift = 1'b0;
        imm_ext_valid = 1'b0;
        imm_ext_value = 24'h00_0000;
    end

    task automatic send(input logic [31:0] w, input logic m, input logic s, input logic ev, input logic [23:0] ex);
        @(posedge clock);
        #1;
        instr_valid = 1'b1;
        instr_word = w;
        is_mult = m;
        is_shift = s;
        imm_ext_valid = ev;
        imm_ext_value = ex;
    endtask

    // Released word and extension lines show the inverse, so stale values never look valid
    task automatic idle();
        @(posedge clock);
        #1;
        instr_valid = 1'b0;
        instr_word = ~instr_word;
        imm_ext_valid = 1'b0;
        imm_ext_value = ~imm_ext_value;
    endtask
endmodule
`default_nettype wire

/* File: dv/compute_and_int_alu_decoder_tb.sv */
/*
 * Self-checking bench for the instruction decoder.
 * Assumes the sequencer stand-in and one-cycle registered decode.
 */
`timescale 1ns/100ps
`default_nettype none
module compute_and_int_alu_decoder_tb;
    logic clock;
    logic rst;
    logic iv, im, is, iev;
    logic [31:0] iw;
    logic [23:0] iex;
    logic dv, ill, le, ce, iop, ireg, iu, simm, mi, mu, ms, mt, mc, mr, msa, msr, mf, mq;
    logic slong, sshort, sse, szf, sbd, sbi;
    logic [4:0] iopc, ires, is1, is2, msub;
    logic [31:0] iimm;
    logic [1:0] msz, msg, macc, sbop;
    logic [3:0] smag;
    logic [6:0] simmv;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    // ****************************************************************
    // Structure
    // ****************************************************************
    cad_seq_model seq (.clock(clock), .instr_valid(iv), .instr_word(iw), .is_mult(im), .is_shift(is),
        .imm_ext_valid(iev), .imm_ext_value(iex));
    cad_decoder dut (.CLOCK(clock), .RST(rst), .INSTR_VALID(iv), .INSTR_WORD(iw), .IS_MULT(im), .IS_SHIFT(is),
        .IMM_EXT_VALID(iev), .IMM_EXT_VALUE(iex), .DEC_VALID(dv), .ILLEGAL(ill), .LINE_END(le), .COND_EXEC(ce),
        .INT_OP(iop), .INT_REGULAR(ireg), .INT_UNIT_SEL(iu), .INT_OPCODE(iopc), .INT_RESULT_REG(ires),
        .INT_SRC1_REG(is1), .INT_SRC2_REG(is2), .INT_SRC2_IMM(simm), .INT_IMM(iimm), .MOVE_SIZE(msz),
        .MUL_SIGN(msg), .MUL_INTEGER(mi), .MUL_UNSIGNED(mu), .MUL_SATURATE(ms), .MUL_TRUNCATE(mt),
        .MUL_ACC_CLEAR(mc), .MUL_ACC_ROUND_SET(mr), .MUL_ACC_SEL(macc), .MUL_SUBOP(msub), .MUL_SUBOP_ACC(msa),
        .MUL_SUBOP_READ(msr), .MUL_FLOAT(mf), .MUL_OVF_QUAD(mq), .SHF_MAG_BITS(smag), .SHF_IMM(simmv),
        .SHF_LONG(slong), .SHF_SHORT(sshort), .SHF_SIGN_EXT(sse), .SHF_ZERO_FILL(szf), .SHF_BIT_DUAL(sbd),
        .SHF_BIT_IMM(sbi), .SHF_BIT_OP(sbop));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Ceiling well above the roughly 90 cycles the run needs
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [31:0] cw(input logic [3:0] t, input logic [4:0] o, input logic [4:0] d,
        input logic [4:0] s1);
        return {3'b001, 4'h0, t, d, 3'b000, s1, 3'b000, o};
    endfunction

    function automatic logic [31:0] xw(input logic ex, input logic cc, input logic u, input logic [1:0] k,
        input logic [4:0] op, input logic [4:0] d, input logic imm, input logic [4:0] s1, input logic [7:0] lo);
        return {ex, cc, 1'b0, u, k, op, d, 2'b00, imm, s1, lo};
    endfunction

    // One word, then idle, so its decode stands at the call's return
    task automatic one(input logic [31:0] w, input logic m, input logic s);
        seq.send(w, m, s, 1'b0, 24'h00_0000);
        seq.idle();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_int();
        seq.send(xw(1'b1, 1'b1, 1'b1, 2'h3, 5'h15, 5'h0A, 1'b0, 5'h13, 8'h3A), 1'b1, 1'b0, 1'b0, 24'h00_0000);
        seq.send(xw(1'b0, 1'b0, 1'b0, 2'h1, 5'h01, 5'h02, 1'b0, 5'h03, 8'h00), 1'b0, 1'b0, 1'b0, 24'h00_0000);
        chk("int_op", 1, iop);
        chk("int_regular", 1, ireg);
        chk("unit", 1, iu);
        chk("src2", 5'h1D, is2);
        chk("fields", {5'h15, 5'h0A, 5'h13}, {iopc, ires, is1});
        chk("ends_cond", 2'b11, {le, ce});
        chk("illegal", 0, ill);
        seq.idle();
        chk("second", 5'b10000, {iop, ireg, iu, le, ce});
        seq.idle();
        chk("idle", 0, dv);
    endtask

    task automatic t_imm();
        seq.send(xw(1'b0, 1'b0, 1'b0, 2'h3, 5'h00, 5'h01, 1'b1, 5'h02, 8'hA0), 1'b0, 1'b0, 1'b0, 24'h00_0000);
        seq.send(xw(1'b0, 1'b0, 1'b0, 2'h3, 5'h00, 5'h01, 1'b1, 5'h02, 8'hA0), 1'b0, 1'b0, 1'b1, 24'h00_0002);
        chk("imm8", 32'hFFFF_FFA0, iimm);
        chk("imm_sel", 6'b100000, {simm, is2});
        seq.send(xw(1'b0, 1'b0, 1'b0, 2'h3, 5'h00, 5'h01, 1'b1, 5'h02, 8'h7F), 1'b0, 1'b0, 1'b0, 24'h00_0000);
        chk("imm32", 32'h0000_02A0, iimm);
        seq.idle();
        chk("imm8_pos", 32'h0000_007F, iimm);
    endtask

    task automatic t_move();
        one(xw(1'b0, 1'b0, 1'b0, 2'h2, 5'h00, 5'h00, 1'b0, 5'h00, 8'h01), 1'b0, 1'b0);
        chk("move_word", 0, msz);
        for (int q = 0; q < 2; q++) begin
            one(xw(1'b0, 1'b0, 1'b0, 2'h2, 5'h00, 5'h00, 1'b0, 5'h00, q[7:0]) | 32'h0000_4000, 1'b0, 1'b0);
            chk("move_lq", q + 1, msz);
        end
    endtask

    task automatic t_mul();
        for (int k = 0; k < 4; k++) begin
            one(cw(4'h0, {k[1], 1'b0, k[0], 2'b00}, 5'h00, 5'h00), 1'b1, 1'b0);
            chk("sign", k, msg);
            chk("unsigned", k[1], mu);
            chk("sign_bad", k == 3, ill);
        end
        one(cw(4'h1, 5'b00001, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("sign_y0", 1, msg);
        one(cw(4'h0, 5'b00011, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("frac_sat_trunc", 3'b011, {mi, ms, mt});
        one(cw(4'h0, 5'b01010, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("int_no_trunc", 3'b100, {mi, ms, mt});
        for (int k = 0; k < 3; k++) begin
            one(cw(4'h4, {2'b00, k[0] | k[1], k[1], 1'b1}, 5'h00, 5'h00), 1'b1, 1'b0);
            chk("clear_round", {k[0] | k[1], k[1]}, {mc, mr});
        end
        for (int k = 0; k < 4; k++) begin
            one(cw(4'hC, {3'b000, k[1:0]}, 5'h00, 5'h00), 1'b1, 1'b0);
            chk("acc_sel", k, macc);
            chk("acc_bad", k == 3, ill);
        end
    endtask

    task automatic t_mtype();
        one(cw(4'hD, 5'b00001, 5'h10, 5'h00), 1'b1, 1'b0);
        chk("acc_only", {1'b1, 1'b0, 5'h10, 1'b0}, {msa, msr, msub, ill});
        one(cw(4'hD, 5'b00001, 5'h11, 5'h00), 1'b1, 1'b0);
        chk("acc_only_bad", 1, ill);
        one(cw(4'hE, 5'b00000, 5'h00, 5'h08), 1'b1, 1'b0);
        chk("readout", {1'b0, 1'b1, 5'h08, 1'b0}, {msa, msr, msub, ill});
        one(cw(4'hE, 5'b00000, 5'h00, 5'h09), 1'b1, 1'b0);
        chk("readout_bad", 1, ill);
        one(cw(4'hF, 5'b00010, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("float", 1, mf);
        one(cw(4'h3, 5'b00000, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("ovf_quad", 1, mq);
        one(cw(4'h1, 5'b00000, 5'h00, 5'h00), 1'b1, 1'b0);
        chk("ovf_pair", 0, mq);
    endtask

    task automatic t_shift();
        one(cw(4'h0, 5'h01, 5'h00, 5'h00) | 32'h0000_0020, 1'b0, 1'b1);
        chk("imm6_mag", {7'h30, 4'd7}, {simmv, smag});
        one(cw(4'h4, 5'h01, 5'h00, 5'h00), 1'b0, 1'b1);
        chk("imm7_long", {7'h20, 4'd8, 1'b1}, {simmv, smag, slong});
        one(cw(4'h4, 5'h1A, 5'h00, 5'h00), 1'b0, 1'b1);
        chk("dual", {4'd7, 1'b0}, {smag, slong});
        for (int k = 0; k < 2; k++) begin
            one(cw(4'h8, {4'h0, k[0]}, 5'h00, 5'h00), 1'b0, 1'b1);
            chk("short_byte", {4'(5 + k), k[0]}, {smag, sshort});
        end
        one(cw(4'h2, 5'h03, 5'h00, 5'h00), 1'b0, 1'b1);
        chk("deposit", 2'b11, {sse, szf});
        one(cw(4'h1, 5'h05, 5'h00, 5'h00), 1'b0, 1'b1);
        chk("extract", 2'b10, {sse, szf});
        for (int k = 0; k < 4; k++) begin
            one(cw(4'hB, {k[1:0], k[0], k[1], 1'b1}, 5'h00, 5'h00), 1'b0, 1'b1);
            chk("bit_op", {k[1:0], k[1], k[0], 1'b1}, {sbop, sbd, sbi, simmv[5]});
        end
        one(cw(4'h7, 5'h00, 5'h00, 5'h00), 1'b0, 1'b1);
        chk("shift_bad", 1, ill);
    endtask

    task automatic t_reset();
        seq.send(xw(1'b1, 1'b0, 1'b0, 2'h3, 5'h01, 5'h01, 1'b0, 5'h01, 8'h02), 1'b0, 1'b0, 1'b0, 24'h00_0000);
        rst = 1'b1;
        seq.idle();
        chk("reset_mid", 3'b000, {dv, iop, le});
        rst = 1'b0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        chk("reset_out", 0, {dv, ill, iop, iimm[7:0], msg, smag});
        t_int();
        t_imm();
        t_move();
        t_mul();
        t_mtype();
        t_shift();
        t_reset();
        t_int();
        stop_test();
    end
endmodule
`default_nettype wire
